// ==== verilog/bmam_defines.vh ====
// Constants for the battery message scheduler and status word logic.
`ifndef BMAM_DEFINES_VH
`define BMAM_DEFINES_VH

// Clock rate and the one-second prescaler derived from it.
`define BMAM_CLK_HZ           125000000
`define BMAM_SEC_S            1
`define BMAM_SEC_CYCLES       (`BMAM_CLK_HZ * `BMAM_SEC_S)

// Message intervals and recovery hold times, in seconds.
`define BMAM_CHG_PERIOD_S     7'h1E
`define BMAM_ALARM_PERIOD_S   7'h0A
`define BMAM_RECOVER_S        7'h46

// Write-word command codes.
`define BMAM_CMD_CURRENT      8'h14
`define BMAM_CMD_VOLTAGE      8'h15
`define BMAM_CMD_ALARM        8'h16

// Mode configuration word: charger broadcast inhibit bit.
`define BMAM_MODE_CHG_INHIBIT 14

// Status word bit positions.
`define BMAM_ST_OVERCHG       15
`define BMAM_ST_CHGSTOP       14
`define BMAM_ST_RSVD13        13
`define BMAM_ST_OVERTEMP      12
`define BMAM_ST_DSGSTOP       11
`define BMAM_ST_RSVD10        10
`define BMAM_ST_CAPALARM      9
`define BMAM_ST_TIMEALARM     8
`define BMAM_ST_READY         7
`define BMAM_ST_DSG           6
`define BMAM_ST_FULL          5
`define BMAM_ST_EMPTY         4
`define BMAM_STATUS_RESET     16'h02C0
`define BMAM_ALARM_MASK       16'hDB00

// Gauge and protection thresholds.
`define BMAM_OVERCHG_MARGIN   17'h0012C
`define BMAM_OVERCHG_CLR_MAH  2'h2
`define BMAM_COV_MV           16'h109A
`define BMAM_COV_REC_MV       16'h1036
`define BMAM_OCC_MA           16'h1194
`define BMAM_IDLE_MA          16'h00C8
`define BMAM_OTC_C            8'h3A
`define BMAM_OTC_REC_C        8'h37
`define BMAM_OTD_C            8'h4B
`define BMAM_OTD_REC_C        8'h41
`define BMAM_CUV_MV           16'h09C4
`define BMAM_CUV_REC_MV       16'h0BB8
`define BMAM_OCD_MA           16'h2904
`define BMAM_PCT_ZERO         8'h00
`define BMAM_PCT_DSG_REC      8'h01
`define BMAM_PCT_FULL_CLR     8'h5F
`define BMAM_PCT_EMPTY_CLR    8'h14

// Maximum error tracking.
`define BMAM_MAXERR_RESET     8'h64
`define BMAM_MAXERR_LEARNED   8'h01
`define BMAM_MAXERR_STEP      5'h14

`endif

// ==== verilog/bmam_sec_timer.v ====
// Seconds timer that reports when a fixed number of seconds has elapsed.
`timescale 1ns/10ps
module bmam_sec_timer (
	input  wire       i_clk,
	input  wire       i_reset,
	input  wire       i_clear,
	input  wire       i_sec_tick,
	input  wire [6:0] i_limit,
	output wire       o_done
);
	reg [6:0] count_reg;
	reg [6:0] count_next;

	// The count saturates at the limit so that done stays up until cleared.
	always @* begin
		count_next = count_reg;
		if (i_clear) begin
			count_next = 7'h00;
		end else if (i_sec_tick && (count_reg != i_limit)) begin
			count_next = count_reg + 7'h01;
		end
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			count_reg <= 7'h00;
		end else begin
			count_reg <= count_next;
		end
	end

	assign o_done = (count_reg == i_limit);
endmodule // bmam_sec_timer

// ==== verilog/bmam_top.v ====
// Battery message scheduler, status word flags and maximum error tracking.
`timescale 1ns/10ps
`include "bmam_defines.vh"

// Summary of operation
// - Battery masters charger requests as write-word.
// - Charger requests repeat while broadcast not inhibited.
// - Charge current request uses command 0x14.
// - Charge voltage request uses command 0x15.
// - Critical condition sends alarm notice 0x16.
// - Alarm notice repeats every 10 seconds.
// - Overcharge bit sets above full+300, clears.
// - Charge stop bit sets on charge faults.
// - Charge stop clears at 95% or recovery.
// - Over-temperature bit sets, disables switch, recovers.
// - Discharge stop bit sets on discharge faults.
// - Discharge stop clears at 1% or recovery.
// - Capacity alarm bit follows user threshold.
// - Runtime alarm bit follows user threshold.
// - Discharging flag is set unless charging.
// - Fully charged sets on termination, clears 95%.
// - Fully discharged sets at 0%, clears 20%.
// - Maximum error grows per 20 cycles or days.
// - Status word readable, resets to 0x2C0.
module bmam_top #(
	parameter SEC_CYCLES = `BMAM_SEC_CYCLES
) (
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire [15:0] i_mode_config_word,
	input  wire [15:0] i_requested_charge_current,
	input  wire [15:0] i_requested_charge_voltage,
	input  wire [15:0] i_capacity_left,
	input  wire [15:0] i_capacity_at_full,
	input  wire [7:0]  i_charge_percent,
	input  wire [15:0] i_capacity_alarm_threshold,
	input  wire [15:0] i_runtime_alarm_threshold,
	input  wire [15:0] i_averaged_runtime_left,
	input  wire [15:0] i_max_cell_mv,
	input  wire [15:0] i_min_cell_mv,
	input  wire [15:0] i_current_ma,
	input  wire [7:0]  i_temp_c,
	input  wire        i_charging,
	input  wire        i_gauge_ready_flag,
	input  wire        i_primary_charge_term,
	input  wire        i_discharge_mah_tick,
	input  wire        i_cycle_tick,
	input  wire        i_day_tick,
	input  wire        i_learn_done,
	input  wire        i_msg_done,
	output wire        o_msg_valid,
	output wire [7:0]  o_msg_cmd,
	output wire [15:0] o_msg_data,
	output wire        o_msg_to_host,
	output wire [15:0] o_pack_status_word,
	output wire        o_stop_charge,
	output wire        o_stop_discharge,
	output wire        o_charge_switch_off,
	output wire        o_discharge_switch_off,
	output wire [7:0]  o_max_error
);
	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	reg        state_reg;
	reg        state_next;
	reg        msg_valid_reg;
	reg        msg_valid_next;
	reg [7:0]  msg_cmd_reg;
	reg [7:0]  msg_cmd_next;
	reg [15:0] msg_data_reg;
	reg [15:0] msg_data_next;
	reg        msg_host_reg;
	reg        msg_host_next;
	reg        alarm_due_reg;
	reg        alarm_due_next;
	reg        curr_due_reg;
	reg        curr_due_next;
	reg        volt_due_reg;
	reg        volt_due_next;
	reg [31:0] presc_reg;
	reg        sec_tick_reg;
	reg [15:0] status_reg;
	reg [15:0] status_next;
	reg [1:0]  ovc_mah_reg;
	reg        cov_reg;
	reg        occ_reg;
	reg        otc_reg;
	reg        cuv_reg;
	reg        ocd_reg;
	reg        otd_reg;
	reg        crit_prev_reg;
	reg        stop_chg_reg;
	reg        stop_dsg_reg;
	reg [7:0]  max_err_reg;
	reg [4:0]  cyc_cnt_reg;
	reg [4:0]  day_cnt_reg;

	wire chg_inhibit = i_mode_config_word[`BMAM_MODE_CHG_INHIBIT];
	wire critical    = |(status_reg & `BMAM_ALARM_MASK);
	wire chg_done;
	wire alarm_done;
	wire occ_hold_done;
	wire ocd_hold_done;
	wire idle_cur    = (i_current_ma <= `BMAM_IDLE_MA);
	wire chg_start   = chg_done && !chg_inhibit;
	wire alarm_start = critical && (!crit_prev_reg || alarm_done);

	// One-second tick shared by every seconds timer.
	always @(posedge i_clk) begin
		if (i_reset) begin
			presc_reg    <= 32'h0000_0000;
			sec_tick_reg <= 1'b0;
		end else if (presc_reg == SEC_CYCLES - 1) begin
			presc_reg    <= 32'h0000_0000;
			sec_tick_reg <= 1'b1;
		end else begin
			presc_reg    <= presc_reg + 32'h0000_0001;
			sec_tick_reg <= 1'b0;
		end
	end

	// Interval between charger request rounds, held at zero while inhibited.
	bmam_sec_timer u_chg_timer (
		.i_clk      (i_clk),
		.i_reset    (i_reset),
		.i_clear    (chg_start || chg_inhibit),
		.i_sec_tick (sec_tick_reg),
		.i_limit    (`BMAM_CHG_PERIOD_S),
		.o_done     (chg_done)
	);

	bmam_sec_timer u_alarm_timer (
		.i_clk      (i_clk),
		.i_reset    (i_reset),
		.i_clear    (alarm_start || !critical),
		.i_sec_tick (sec_tick_reg),
		.i_limit    (`BMAM_ALARM_PERIOD_S),
		.o_done     (alarm_done)
	);

	// Over-current recovery needs the idle current to hold unbroken.
	bmam_sec_timer u_occ_timer (
		.i_clk      (i_clk),
		.i_reset    (i_reset),
		.i_clear    (!(occ_reg && idle_cur)),
		.i_sec_tick (sec_tick_reg),
		.i_limit    (`BMAM_RECOVER_S),
		.o_done     (occ_hold_done)
	);

	bmam_sec_timer u_ocd_timer (
		.i_clk      (i_clk),
		.i_reset    (i_reset),
		.i_clear    (!(ocd_reg && idle_cur)),
		.i_sec_tick (sec_tick_reg),
		.i_limit    (`BMAM_RECOVER_S),
		.o_done     (ocd_hold_done)
	);

	// Protection trip latches; each sets at its limit, clears at recovery.
	wire cov_set = i_charging && (i_max_cell_mv >= `BMAM_COV_MV);
	wire occ_set = i_charging && (i_current_ma >= `BMAM_OCC_MA);
	wire otc_set = i_charging && (i_temp_c >= `BMAM_OTC_C);
	wire cuv_set = !i_charging && (i_min_cell_mv <= `BMAM_CUV_MV);
	wire ocd_set = !i_charging && (i_current_ma >= `BMAM_OCD_MA);
	wire otd_set = !i_charging && (i_temp_c >= `BMAM_OTD_C);
	wire cov_rec = cov_reg && (i_max_cell_mv <= `BMAM_COV_REC_MV);
	wire occ_rec = occ_reg && occ_hold_done;
	wire otc_rec = otc_reg && (i_temp_c <= `BMAM_OTC_REC_C);
	wire cuv_rec = cuv_reg && (i_min_cell_mv >= `BMAM_CUV_REC_MV);
	wire ocd_rec = ocd_reg && ocd_hold_done;
	wire otd_rec = otd_reg && (i_temp_c <= `BMAM_OTD_REC_C);

	always @(posedge i_clk) begin
		if (i_reset) begin
			cov_reg <= 1'b0;
			occ_reg <= 1'b0;
			otc_reg <= 1'b0;
			cuv_reg <= 1'b0;
			ocd_reg <= 1'b0;
			otd_reg <= 1'b0;
		end else begin
			cov_reg <= cov_set || (cov_reg && !cov_rec);
			occ_reg <= occ_set || (occ_reg && !occ_rec);
			otc_reg <= otc_set || (otc_reg && !otc_rec);
			cuv_reg <= cuv_set || (cuv_reg && !cuv_rec);
			ocd_reg <= ocd_set || (ocd_reg && !ocd_rec);
			otd_reg <= otd_set || (otd_reg && !otd_rec);
		end
	end

	wire [16:0] full_plus = {1'b0, i_capacity_at_full} + `BMAM_OVERCHG_MARGIN;
	wire ovc_set  = ({1'b0, i_capacity_left} > full_plus);
	wire ovc_clr  = status_reg[`BMAM_ST_OVERCHG] && i_discharge_mah_tick &&
			(ovc_mah_reg == `BMAM_OVERCHG_CLR_MAH - 2'h1);
	wire cstop_set = i_primary_charge_term || cov_set || occ_set || otc_set;
	wire cstop_clr = (i_charge_percent <= `BMAM_PCT_FULL_CLR) || cov_rec || occ_rec ||
			otc_rec;
	wire dstop_set = (i_charge_percent <= `BMAM_PCT_ZERO) || cuv_set || ocd_set || otd_set;
	wire dstop_clr = (i_charge_percent >= `BMAM_PCT_DSG_REC) || cuv_rec || ocd_rec ||
			otd_rec;

	// Discharge counted after the overcharge alarm, to release it.
	always @(posedge i_clk) begin
		if (i_reset || !status_reg[`BMAM_ST_OVERCHG] || ovc_set) begin
			ovc_mah_reg <= 2'h0;
		end else if (i_discharge_mah_tick && !ovc_clr) begin
			ovc_mah_reg <= ovc_mah_reg + 2'h1;
		end
	end

	// A set condition present in the same cycle as its clear keeps the bit.
	always @* begin
		status_next = status_reg;
		status_next[`BMAM_ST_OVERCHG] = ovc_set ||
			(status_reg[`BMAM_ST_OVERCHG] && !ovc_clr);
		status_next[`BMAM_ST_CHGSTOP] = cstop_set ||
			(status_reg[`BMAM_ST_CHGSTOP] && !cstop_clr);
		status_next[`BMAM_ST_RSVD13] = 1'b0;
		status_next[`BMAM_ST_OVERTEMP] = otc_reg || otd_reg;
		status_next[`BMAM_ST_DSGSTOP] = dstop_set ||
			(status_reg[`BMAM_ST_DSGSTOP] && !dstop_clr);
		status_next[`BMAM_ST_RSVD10] = 1'b0;
		status_next[`BMAM_ST_CAPALARM] = (i_capacity_alarm_threshold != 16'h0000) &&
			(i_capacity_left < i_capacity_alarm_threshold);
		status_next[`BMAM_ST_TIMEALARM] = (i_runtime_alarm_threshold != 16'h0000) &&
			(i_averaged_runtime_left < i_runtime_alarm_threshold);
		status_next[`BMAM_ST_READY] = i_gauge_ready_flag;
		status_next[`BMAM_ST_DSG] = !i_charging;
		status_next[`BMAM_ST_FULL] = i_primary_charge_term ||
			(status_reg[`BMAM_ST_FULL] &&
			!(i_charge_percent <= `BMAM_PCT_FULL_CLR));
		status_next[`BMAM_ST_EMPTY] = (i_charge_percent <= `BMAM_PCT_ZERO) ||
			(status_reg[`BMAM_ST_EMPTY] &&
			!(i_charge_percent >= `BMAM_PCT_EMPTY_CLR));
		status_next[3:0] = 4'h0;
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			status_reg    <= `BMAM_STATUS_RESET;
			crit_prev_reg <= 1'b0;
			stop_chg_reg  <= 1'b0;
			stop_dsg_reg  <= 1'b0;
		end else begin
			status_reg    <= status_next;
			crit_prev_reg <= critical;
			stop_chg_reg  <= status_next[`BMAM_ST_OVERCHG] ||
				status_next[`BMAM_ST_CHGSTOP] || status_next[`BMAM_ST_FULL];
			stop_dsg_reg  <= status_next[`BMAM_ST_DSGSTOP] ||
				status_next[`BMAM_ST_EMPTY];
		end
	end

	// Maximum error: one point per twenty cycles or days, capped at reset value.
	wire cyc_wrap = i_cycle_tick && (cyc_cnt_reg == `BMAM_MAXERR_STEP - 5'h01);
	wire day_wrap = i_day_tick && (day_cnt_reg == `BMAM_MAXERR_STEP - 5'h01);
	wire [7:0] err_inc = {7'h00, cyc_wrap} + {7'h00, day_wrap};

	always @(posedge i_clk) begin
		if (i_reset) begin
			max_err_reg <= `BMAM_MAXERR_RESET;
			cyc_cnt_reg <= 5'h00;
			day_cnt_reg <= 5'h00;
		end else if (i_learn_done) begin
			max_err_reg <= `BMAM_MAXERR_LEARNED;
			cyc_cnt_reg <= 5'h00;
			day_cnt_reg <= 5'h00;
		end else begin
			if (i_cycle_tick) begin
				cyc_cnt_reg <= cyc_wrap ? 5'h00 : cyc_cnt_reg + 5'h01;
			end
			if (i_day_tick) begin
				day_cnt_reg <= day_wrap ? 5'h00 : day_cnt_reg + 5'h01;
			end
			if (max_err_reg + err_inc >= `BMAM_MAXERR_RESET) begin
				max_err_reg <= `BMAM_MAXERR_RESET;
			end else begin
				max_err_reg <= max_err_reg + err_inc;
			end
		end
	end

	// Message scheduler. Alarm notices outrank charger requests, and a due
	// flag raised while its own message is in flight is kept for later.
	always @* begin
		state_next     = state_reg;
		msg_valid_next = msg_valid_reg;
		msg_cmd_next   = msg_cmd_reg;
		msg_data_next  = msg_data_reg;
		msg_host_next  = msg_host_reg;
		alarm_due_next = alarm_due_reg || alarm_start;
		curr_due_next  = curr_due_reg || chg_start;
		volt_due_next  = volt_due_reg || chg_start;
		if (!critical) begin
			alarm_due_next = 1'b0;
		end
		if (chg_inhibit) begin
			curr_due_next = 1'b0;
			volt_due_next = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				if (alarm_due_reg && critical) begin
					msg_cmd_next   = `BMAM_CMD_ALARM;
					msg_data_next  = status_reg;
					msg_host_next  = 1'b1;
					alarm_due_next = alarm_start;
					msg_valid_next = 1'b1;
					state_next     = ST_SEND;
				end else if (curr_due_reg && !chg_inhibit) begin
					msg_cmd_next   = `BMAM_CMD_CURRENT;
					msg_data_next  = i_requested_charge_current;
					msg_host_next  = 1'b0;
					curr_due_next  = chg_start;
					msg_valid_next = 1'b1;
					state_next     = ST_SEND;
				end else if (volt_due_reg && !chg_inhibit) begin
					msg_cmd_next   = `BMAM_CMD_VOLTAGE;
					msg_data_next  = i_requested_charge_voltage;
					msg_host_next  = 1'b0;
					volt_due_next  = chg_start;
					msg_valid_next = 1'b1;
					state_next     = ST_SEND;
				end
			end
			ST_SEND: begin
				if (i_msg_done) begin
					msg_valid_next = 1'b0;
					state_next     = ST_IDLE;
				end
			end
			default: begin
				msg_valid_next = 1'b0;
				state_next     = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			state_reg     <= ST_IDLE;
			msg_valid_reg <= 1'b0;
			msg_cmd_reg   <= 8'h00;
			msg_data_reg  <= 16'h0000;
			msg_host_reg  <= 1'b0;
			alarm_due_reg <= 1'b0;
			curr_due_reg  <= 1'b0;
			volt_due_reg  <= 1'b0;
		end else begin
			state_reg     <= state_next;
			msg_valid_reg <= msg_valid_next;
			msg_cmd_reg   <= msg_cmd_next;
			msg_data_reg  <= msg_data_next;
			msg_host_reg  <= msg_host_next;
			alarm_due_reg <= alarm_due_next;
			curr_due_reg  <= curr_due_next;
			volt_due_reg  <= volt_due_next;
		end
	end

	assign o_msg_valid            = msg_valid_reg;
	assign o_msg_cmd              = msg_cmd_reg;
	assign o_msg_data             = msg_data_reg;
	assign o_msg_to_host          = msg_host_reg;
	assign o_pack_status_word     = status_reg;
	assign o_stop_charge          = stop_chg_reg;
	assign o_stop_discharge       = stop_dsg_reg;
	assign o_charge_switch_off    = otc_reg;
	assign o_discharge_switch_off = otd_reg;
	assign o_max_error            = max_err_reg;
endmodule // bmam_top

// ==== dv/bmam_checker.sv ====
// Concurrent checks on the message port and status word of the scheduler.
`timescale 1ns/10ps
module bmam_checker #(
	parameter SEC_CYCLES = 10
) (
	input wire        i_clk,
	input wire        i_reset,
	input wire [15:0] i_mode_config_word,
	input wire [15:0] i_capacity_left,
	input wire [15:0] i_capacity_alarm_threshold,
	input wire        i_charging,
	input wire        i_gauge_ready_flag,
	input wire        i_msg_done,
	input wire        o_msg_valid,
	input wire [7:0]  o_msg_cmd,
	input wire [15:0] o_msg_data,
	input wire        o_msg_to_host,
	input wire [15:0] o_pack_status_word,
	input wire        o_stop_charge,
	input wire        o_stop_discharge
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	sequence s_word_taken;
		o_msg_valid && i_msg_done;
	endsequence
	sequence s_launch;
		!o_msg_valid ##1 o_msg_valid;
	endsequence
	reset_status_a: assert property ($past(i_reset) |-> o_pack_status_word == 16'h02C0)
		else $error("status word not at reset value");
	legal_cmd_a: assert property (o_msg_valid |-> o_msg_cmd inside {8'h14, 8'h15, 8'h16}
		&& o_msg_to_host == (o_msg_cmd == 8'h16)) else $error("bad command or target");
	word_hold_a: assert property (o_msg_valid && !i_msg_done |=> o_msg_valid
		&& $stable(o_msg_cmd) && $stable(o_msg_data)) else $error("word changed before done");
	word_release_a: assert property (s_word_taken |=> !o_msg_valid)
		else $error("valid held after done");
	alarm_layout_a: assert property (o_msg_valid && o_msg_cmd == 8'h16 |->
		(o_msg_data & 16'hDB00) != 0 && (o_msg_data & 16'h240F) == 0) else $error("bad alarm word");
	inhibit_gate_a: assert property (s_launch ##0 o_msg_cmd != 8'h16 |->
		!$past(i_mode_config_word[14])) else $error("charger request while inhibited");
	dsg_flag_a: assert property (!i_reset |=> o_pack_status_word[6] == !$past(i_charging))
		else $error("discharging flag wrong");
	ready_bit_a: assert property (!i_reset |=> o_pack_status_word[7] == $past(i_gauge_ready_flag))
		else $error("ready bit wrong");
	cap_alarm_a: assert property (!i_reset |=> o_pack_status_word[9] ==
		($past(i_capacity_alarm_threshold) != 16'h0000
		&& $past(i_capacity_left) < $past(i_capacity_alarm_threshold))) else $error("capacity bit wrong");
	stop_flags_a: assert property (o_stop_charge == (o_pack_status_word[15] |
		o_pack_status_word[14] | o_pack_status_word[5])
		&& o_stop_discharge == (o_pack_status_word[11] | o_pack_status_word[4]))
		else $error("stop request disagrees with status");
	reserved_zero_a: assert property ((o_pack_status_word & 16'h240F) == 16'h0000)
		else $error("reserved status bit set");
endmodule // bmam_checker

bind bmam_top bmam_checker #(.SEC_CYCLES(SEC_CYCLES)) u_bmam_checker (
	.i_clk, .i_reset, .i_mode_config_word, .i_capacity_left, .i_capacity_alarm_threshold,
	.i_charging, .i_gauge_ready_flag, .i_msg_done, .o_msg_valid, .o_msg_cmd, .o_msg_data,
	.o_msg_to_host, .o_pack_status_word, .o_stop_charge, .o_stop_discharge
);

// ==== dv/bmam_engine.sv ====
// Behavioural bus engine and far-side receiver that acknowledges each write-word.
`timescale 1ns/10ps
module bmam_engine (
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire        i_slow,
	input  wire        i_msg_valid,
	input  wire [7:0]  i_msg_cmd,
	input  wire [15:0] i_msg_data,
	input  wire        i_msg_to_host,
	output logic       o_msg_done = 1'b0
);
	logic [4:0]  wait_reg = 5'h00;
	logic [24:0] log_q[$];
	int          t_q[$];
	int          cyc = 0;

	// A slow receiver stretches the word so the scheduler has to hold it.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (i_msg_valid && o_msg_done) begin
			log_q.push_back({i_msg_to_host, i_msg_cmd, i_msg_data});
			t_q.push_back(cyc);
		end
		if (i_reset || !i_msg_valid || o_msg_done) begin
			o_msg_done <= 1'b0;
			wait_reg <= 5'h00;
		end else if (wait_reg == (i_slow ? 5'h14 : 5'h02)) begin
			o_msg_done <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 5'h01;
		end
	end
endmodule // bmam_engine

// ==== dv/test_battery_master_alarm_messaging.sv ====
// Self-checking bench for the battery message scheduler and status word.
`timescale 1ns/10ps
module test_battery_master_alarm_messaging;
	logic        i_clk = 1'b0;
	logic        i_reset, i_charging, i_gauge_ready_flag, i_msg_done, i_slow;
	logic [15:0] i_mode_config_word, i_requested_charge_current, i_requested_charge_voltage;
	logic [15:0] i_capacity_left, i_capacity_at_full, i_capacity_alarm_threshold;
	logic [15:0] i_runtime_alarm_threshold, i_averaged_runtime_left, i_max_cell_mv;
	logic [15:0] i_min_cell_mv, i_current_ma, o_msg_data, o_pack_status_word;
	logic [7:0]  i_charge_percent, i_temp_c, o_msg_cmd, o_max_error;
	logic [4:0]  pul;
	logic        o_msg_valid, o_msg_to_host, o_stop_charge, o_stop_discharge;
	logic        o_charge_switch_off, o_discharge_switch_off;
	int          n_errors = 0;
	int          checked = 0;
	int          t1, t2, t3;

	bmam_top #(.SEC_CYCLES(10)) i_bmam_top (
		.i_clk, .i_reset, .i_mode_config_word, .i_requested_charge_current,
		.i_requested_charge_voltage, .i_capacity_left, .i_capacity_at_full, .i_charge_percent,
		.i_capacity_alarm_threshold, .i_runtime_alarm_threshold, .i_averaged_runtime_left,
		.i_max_cell_mv, .i_min_cell_mv, .i_current_ma, .i_temp_c, .i_charging,
		.i_gauge_ready_flag, .i_primary_charge_term(pul[0]), .i_discharge_mah_tick(pul[1]),
		.i_cycle_tick(pul[2]), .i_day_tick(pul[3]), .i_learn_done(pul[4]), .i_msg_done,
		.o_msg_valid, .o_msg_cmd, .o_msg_data, .o_msg_to_host, .o_pack_status_word,
		.o_stop_charge, .o_stop_discharge, .o_charge_switch_off, .o_discharge_switch_off,
		.o_max_error
	);
	bmam_engine i_bmam_engine (
		.i_clk, .i_reset, .i_slow, .i_msg_valid(o_msg_valid), .i_msg_cmd(o_msg_cmd),
		.i_msg_data(o_msg_data), .i_msg_to_host(o_msg_to_host), .o_msg_done(i_msg_done)
	);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Outputs are sampled 1 ns after the edge so the design's updates have landed.
	task automatic st(input logic [15:0] e, input logic [3:0] f);
		repeat (3) @(posedge i_clk);
		#1;
		chk("status", e, o_pack_status_word);
		chk("flags", {12'h000, f}, {12'h000, o_stop_charge, o_stop_discharge,
			o_charge_switch_off, o_discharge_switch_off});
		@(posedge i_clk);
	endtask
	task automatic msg(input logic [7:0] c, input logic [15:0] d, input logic h, output int t);
		logic [24:0] w;
		int k;
		for (k = 0; k < 1500 && i_bmam_engine.log_q.size() == 0; k++) begin
			@(posedge i_clk);
			#1;
		end
		t = 0;
		if (i_bmam_engine.log_q.size() == 0) begin
			chk("cmd", {8'h00, c}, 16'h0000);
		end else begin
			w = i_bmam_engine.log_q.pop_front();
			t = i_bmam_engine.t_q.pop_front();
			chk("cmd", {8'h00, c}, {8'h00, w[23:16]});
			chk("data", d, w[15:0]);
			chk("to_host", {15'h0000, h}, {15'h0000, w[24]});
		end
		@(posedge i_clk);
	endtask
	task automatic quiet(input int n);
		repeat (20) @(posedge i_clk);
		#1;
		i_bmam_engine.log_q.delete();
		i_bmam_engine.t_q.delete();
		repeat (n) @(posedge i_clk);
		#1;
		chk("msg_count", 16'h0000, 16'(i_bmam_engine.log_q.size()));
		@(posedge i_clk);
	endtask
	task automatic pulse(input int b, input int n);
		repeat (n) begin
			pul[b] <= 1'b1;
			@(posedge i_clk);
			pul[b] <= 1'b0;
			@(posedge i_clk);
		end
	endtask
	task automatic me(input logic [7:0] e);
		#1;
		chk("max_error", {8'h00, e}, {8'h00, o_max_error});
		@(posedge i_clk);
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial forever #4 i_clk = ~i_clk;
	initial begin
		#480000;
		n_errors++;
		$display("MISMATCH watchdog expected finish seen timeout");
		end_sim;
	end
	initial begin
		i_reset <= 1'b1;
		i_slow <= 1'b0;
		pul <= 5'h00;
		{i_mode_config_word, i_requested_charge_current} <= {16'h0000, 16'h0FA0};
		{i_requested_charge_voltage, i_capacity_left} <= {16'h3138, 16'h03E8};
		{i_capacity_at_full, i_capacity_alarm_threshold} <= {16'h07D0, 16'h0000};
		{i_runtime_alarm_threshold, i_averaged_runtime_left} <= {16'h0000, 16'h0064};
		{i_max_cell_mv, i_min_cell_mv, i_current_ma} <= {16'h0E74, 16'h0E74, 16'h0064};
		{i_charge_percent, i_temp_c, i_charging, i_gauge_ready_flag} <= {8'h32, 8'h19, 2'b01};
		repeat (4) @(posedge i_clk);
		#1;
		chk("status", 16'h02C0, o_pack_status_word);
		chk("max_error", 16'h0064, {8'h00, o_max_error});
		chk("valid", 16'h0000, {15'h0000, o_msg_valid});
		@(posedge i_clk);
		i_reset <= 1'b0;
		st(16'h00C0, 4'h0);
		msg(8'h14, 16'h0FA0, 1'b0, t1);
		i_slow <= 1'b1;
		msg(8'h15, 16'h3138, 1'b0, t2);
		i_slow <= 1'b0;
		msg(8'h14, 16'h0FA0, 1'b0, t3);
		chk("round_gap", 16'h0001, 16'(t3 - t1 >= 100 && t3 - t1 <= 600));
		msg(8'h15, 16'h3138, 1'b0, t2);
		i_mode_config_word <= 16'h4000;
		quiet(700);
		i_capacity_alarm_threshold <= 16'h03E8;
		st(16'h00C0, 4'h0);
		i_capacity_alarm_threshold <= 16'h03E9;
		st(16'h02C0, 4'h0);
		msg(8'h16, 16'h02C0, 1'b1, t1);
		msg(8'h16, 16'h02C0, 1'b1, t2);
		// The first notice is not aligned to the seconds tick, so the gap is timed between repeats.
		msg(8'h16, 16'h02C0, 1'b1, t3);
		chk("alarm_gap", 16'h0001, 16'(t3 - t2 >= 95 && t3 - t2 <= 105));
		i_capacity_alarm_threshold <= 16'h0000;
		i_runtime_alarm_threshold <= 16'h0065;
		st(16'h01C0, 4'h0);
		i_runtime_alarm_threshold <= 16'h0064;
		st(16'h00C0, 4'h0);
		quiet(300);
		i_charging <= 1'b1;
		// Charge kept above the 95% clear point so only recovery can release bit 14.
		i_charge_percent <= 8'h60;
		i_max_cell_mv <= 16'h1099;
		st(16'h0080, 4'h0);
		i_max_cell_mv <= 16'h109A;
		st(16'h4080, 4'h8);
		i_max_cell_mv <= 16'h1036;
		st(16'h0080, 4'h0);
		i_current_ma <= 16'h1194;
		st(16'h4080, 4'h8);
		i_current_ma <= 16'h00C8;
		repeat (600) @(posedge i_clk);
		st(16'h4080, 4'h8);
		repeat (120) @(posedge i_clk);
		st(16'h0080, 4'h0);
		i_temp_c <= 8'h3A;
		st(16'h5080, 4'hA);
		i_temp_c <= 8'h38;
		st(16'h5080, 4'hA);
		i_temp_c <= 8'h37;
		st(16'h0080, 4'h0);
		i_charge_percent <= 8'h60;
		pulse(0, 1);
		st(16'h40A0, 4'h8);
		i_charge_percent <= 8'h5F;
		st(16'h0080, 4'h0);
		i_charging <= 1'b0;
		i_capacity_left <= 16'h08FC;
		st(16'h00C0, 4'h0);
		i_capacity_left <= 16'h08FD;
		st(16'h80C0, 4'h8);
		i_capacity_left <= 16'h03E8;
		pulse(1, 1);
		st(16'h80C0, 4'h8);
		pulse(1, 1);
		st(16'h00C0, 4'h0);
		i_min_cell_mv <= 16'h09C4;
		st(16'h08C0, 4'h4);
		i_min_cell_mv <= 16'h0BB7;
		st(16'h00C0, 4'h0);
		i_min_cell_mv <= 16'h0BB8;
		st(16'h00C0, 4'h0);
		i_current_ma <= 16'h2904;
		st(16'h08C0, 4'h4);
		i_current_ma <= 16'h0064;
		repeat (720) @(posedge i_clk);
		st(16'h00C0, 4'h0);
		i_temp_c <= 8'h4B;
		st(16'h18C0, 4'h5);
		i_temp_c <= 8'h42;
		st(16'h10C0, 4'h1);
		i_temp_c <= 8'h41;
		st(16'h00C0, 4'h0);
		i_charge_percent <= 8'h00;
		st(16'h08D0, 4'h4);
		i_charge_percent <= 8'h01;
		st(16'h00D0, 4'h4);
		i_charge_percent <= 8'h13;
		st(16'h00D0, 4'h4);
		i_charge_percent <= 8'h14;
		st(16'h00C0, 4'h0);
		i_gauge_ready_flag <= 1'b0;
		st(16'h0040, 4'h0);
		pulse(4, 1);
		me(8'h01);
		pulse(2, 19);
		me(8'h01);
		pulse(2, 1);
		me(8'h02);
		pulse(3, 20);
		me(8'h03);
		end_sim;
	end
endmodule // test_battery_master_alarm_messaging
